// ==== verilog/sac_map.vh ====
// Control byte layout, mode codes and timing constants of the sequencer
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// Control byte fields
`define SAC_CB_PWR_HI    7
`define SAC_CB_PWR_LO    6
`define SAC_CB_ACQ       5
`define SAC_CB_PAIR      4
`define SAC_CB_POL       3
`define SAC_CB_CH_HI     2
`define SAC_CB_CH_LO     0
`define SAC_CB_RESET     8'hc0

// Power and clock select codes
`define SAC_PWR_FULL_PD  2'b00
`define SAC_PWR_STANDBY  2'b01
`define SAC_PWR_INT_CLK  2'b10
`define SAC_PWR_EXT_CLK  2'b11

// Conversion and acquisition lengths in conversion-clock cycles
`define SAC_CONV_CYCLES  4'hd
`define SAC_ACQ_EDGES    3'h4
`define SAC_SAR_FIRST    4'h1
`define SAC_SAR_LAST     4'ha
`define SAC_RES_MSB      9
`define SAC_SYNC_FILL    2'h3
`define SAC_TICK_RESTART 7'h01

// Timing: core clock period and internal-clock figures in ns
`define SAC_CLK_PERIOD_NS 10
`define SAC_INT_ACQ_NS    1000
`define SAC_INT_CONV_NS   3600
// Longest times round down to whole core cycles
`define SAC_INT_ACQ_CYC  ((`SAC_INT_ACQ_NS) / (`SAC_CLK_PERIOD_NS))
`define SAC_INT_TICK_CYC ((`SAC_INT_CONV_NS) / (13 * `SAC_CLK_PERIOD_NS))

`endif

// ==== verilog/sac_sequencer.v ====
// Control byte port, track/hold timing and SAR conversion sequencer
`timescale 1ns/100ps
`include "sac_map.vh"

// Overview of operation
// - Every store strobe rising edge, except the one ending external acquisition, puts the sample stage into tracking.
// - External acquisition: hold begins at the next store strobe rising edge.
// - Internal acquisition: hold at fourth falling conversion-clock edge after write.
// - Internal clock with internal acquisition: hold about 1 us after write.
// - Single-ended: negative node to common return, positive to selected channel.
// - Pseudo-differential: negative node to the paired channel of the address.
// - Host write picks channel and polarity; starts acquisition or acquire plus convert.
// - Each conversion lasts 13 conversion-clock falling edges; 13 whole cycles with the internal clock or with internal acquisition.
// - A write during conversion abandons it and starts a new acquisition.
// - Acquisition bit clear: timed acquisition, then conversion starts by itself.
// - External acquisition: write with bit set, then bit clear starts conversion.
// - Power bits may change on the second write without disturbing conversion.
// - Done flag goes low when the conversion result is ready.
// - Done flag returns high on the first read or on any new write.
// - Bits 7:6 codes 00/01 are full and standby power-down, clock unchanged.
// - Code 10 normal with internal clock, code 11 normal with external clock.
// - Bit 5 selects internal acquisition at 0, external at 1.
// - Bit 4 selects pseudo-differential at 0, single-ended at 1.
// - Bit 3 selects bipolar at 0, unipolar at 1.
// - Bits 2:0 are the channel address of the input or input pair.
// - Chip select high ignores strobes and clock, releases data and done pins.
// - Read gives bits 7:0, or 9:8 with zero or sign fill above.
// - Result straight binary when unipolar, two's complement when bipolar.
// - After reset the external conversion clock is selected.
module sac_sequencer (
  input  wire       core_clk_i,
  input  wire       reset_n_i,
  input  wire       cs_n_i,
  input  wire       wr_n_i,
  input  wire       rd_n_i,
  input  wire       upper_byte_select_i,
  input  wire       conv_clk_i,
  input  wire [7:0] parallel_data_pins_i,
  input  wire       comparator_i,
  output wire [7:0] parallel_data_pins_o,
  output wire       parallel_data_oe_n_o,
  output wire       done_n_o,
  output wire       done_oe_n_o,
  output wire       hold_capacitor_hold_o,
  output wire       hold_capacitor_convert_o,
  output wire [2:0] pos_channel_o,
  output wire [2:0] neg_channel_o,
  output wire       neg_to_common_o,
  output wire       polarity_select_o,
  output wire [9:0] dac_code_o,
  output wire       full_power_down_o,
  output wire       standby_o,
  output wire       internal_clock_o
);

  localparam [1:0] ST_IDLE    = 2'b00;
  localparam [1:0] ST_ACQ_EXT = 2'b01;
  localparam [1:0] ST_ACQ_INT = 2'b10;
  localparam [1:0] ST_CONV    = 2'b11;

  localparam integer ACQ_CYC_I  = `SAC_INT_ACQ_CYC;
  localparam integer TICK_CYC_I = `SAC_INT_TICK_CYC;
  localparam [6:0]   ACQ_CYC    = ACQ_CYC_I[6:0];
  localparam [6:0]   TICK_CYC   = TICK_CYC_I[6:0];
  localparam         SYNC_W     = 13;

  // Power codes with bit 7 set are the normal-operation codes
  function is_normal;
    input [1:0] code;
    begin
      is_normal = code[1];
    end
  endfunction

  // Falling-edge decode shared by the fetch strobe and the external clock
  function fell_edge;
    input prev;
    input cur;
    begin
      fell_edge = prev & ~cur;
    end
  endfunction

  function is_idle;
    input [1:0] st;
    begin
      is_idle = (st == ST_IDLE);
    end
  endfunction

  // Pin synchronisers: every asynchronous pin passes two flip-flops
  wire [SYNC_W-1:0] pins_raw;
  reg  [SYNC_W-1:0] sync_meta_r;
  reg  [SYNC_W-1:0] sync_r;
  reg  [SYNC_W-1:0] sync_prev_r;

  assign pins_raw = {cs_n_i, wr_n_i, rd_n_i, upper_byte_select_i,
                     conv_clk_i, parallel_data_pins_i};

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sync_meta_r <= {SYNC_W{1'b1}};
      sync_r      <= {SYNC_W{1'b1}};
      sync_prev_r <= {SYNC_W{1'b1}};
    end else begin
      sync_meta_r <= pins_raw;
      sync_r      <= sync_meta_r;
      sync_prev_r <= sync_r;
    end
  end

  wire       cs_n_s    = sync_r[12];
  wire       wr_n_s    = sync_r[11];
  wire       rd_n_s    = sync_r[10];
  wire       ubs_s     = sync_r[9];
  wire       cclk_s    = sync_r[8];
  wire [7:0] data_s    = sync_r[7:0];
  wire       wr_n_prev = sync_prev_r[11];
  wire       rd_n_prev = sync_prev_r[10];
  wire       cclk_prev = sync_prev_r[8];

  // Sync chain resets high; pin edges count only once real samples fill it
  reg  [1:0] fill_cnt_r;
  wire       sync_full = (fill_cnt_r == `SAC_SYNC_FILL);

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fill_cnt_r <= 2'h0;
    end else if (!sync_full) begin
      fill_cnt_r <= fill_cnt_r + 2'h1;
    end
  end

  // Strobes only count while chip select is low
  wire pins_live = ~cs_n_s & sync_full;
  wire write_evt = pins_live & ~wr_n_prev & wr_n_s;
  wire read_evt  = pins_live & fell_edge(rd_n_prev, rd_n_s);
  wire ext_fall  = pins_live & fell_edge(cclk_prev, cclk_s);

  // Registers
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg       int_clk_r;
  reg       int_clk_nxt;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [6:0] acq_cnt_r;
  reg [6:0] acq_cnt_nxt;
  reg [3:0] step_r;
  reg [3:0] step_nxt;
  reg [9:0] sar_r;
  reg [9:0] sar_nxt;
  reg [9:0] trial_r;
  reg [9:0] trial_nxt;
  reg [9:0] result_r;
  reg [9:0] result_nxt;
  reg       done_n_r;
  reg       done_n_nxt;
  reg [6:0] div_cnt_r;
  reg       int_tick_r;
  reg [7:0] dout_r;

  // Internal conversion clock restarts with each conversion, so its first
  // cycle is whole and the conversion takes exactly 13 ticks
  wire conv_start = (state_nxt == ST_CONV) && (state_r != ST_CONV);

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      div_cnt_r  <= 7'h00;
      int_tick_r <= 1'b0;
    end else if (conv_start) begin
      div_cnt_r  <= `SAC_TICK_RESTART;
      int_tick_r <= 1'b0;
    end else if (div_cnt_r == TICK_CYC - 7'h01) begin
      div_cnt_r  <= 7'h00;
      int_tick_r <= 1'b1;
    end else begin
      div_cnt_r  <= div_cnt_r + 7'h01;
      int_tick_r <= 1'b0;
    end
  end

  wire conv_tick = int_clk_r ? int_tick_r : ext_fall;

  wire [1:0] pwr_code  = ctrl_r[`SAC_CB_PWR_HI:`SAC_CB_PWR_LO];
  wire       uni_mode  = ctrl_r[`SAC_CB_POL];
  wire [1:0] new_pwr   = data_s[`SAC_CB_PWR_HI:`SAC_CB_PWR_LO];
  wire       new_acq   = data_s[`SAC_CB_ACQ];

  // Bipolar SAR code is offset binary; flipping the MSB gives 2's complement
  wire [9:0] fmt_res   = uni_mode ? sar_r :
                         {~sar_r[`SAC_RES_MSB], sar_r[8:0]};

  always @* begin
    ctrl_nxt    = ctrl_r;
    int_clk_nxt = int_clk_r;
    state_nxt   = state_r;
    acq_cnt_nxt = acq_cnt_r;
    step_nxt    = step_r;
    sar_nxt     = sar_r;
    trial_nxt   = trial_r;
    result_nxt  = result_r;
    done_n_nxt  = done_n_r;

    if (read_evt) begin
      done_n_nxt = 1'b1;
    end

    if (write_evt) begin
      ctrl_nxt   = data_s;
      done_n_nxt = 1'b1;
      // Power-down codes keep the last clock choice
      if (is_normal(new_pwr)) begin
        int_clk_nxt = (new_pwr == `SAC_PWR_INT_CLK);
      end
      acq_cnt_nxt = 7'h00;
      if (state_r == ST_ACQ_EXT && !new_acq) begin
        // Second write ends tracking; only the power bits are expected to move
        state_nxt = ST_CONV;
        step_nxt  = 4'h0;
        sar_nxt   = 10'h000;
        trial_nxt = 10'h200;
      end else if (new_acq) begin
        state_nxt = ST_ACQ_EXT;
      end else begin
        state_nxt = ST_ACQ_INT;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_ACQ_EXT: begin
          state_nxt = ST_ACQ_EXT;
        end
        ST_ACQ_INT: begin
          // Internal clock runs on core time, external on pin edges
          if (int_clk_r) begin
            if (acq_cnt_r == ACQ_CYC - 7'h01) begin
              state_nxt = ST_CONV;
            end else begin
              acq_cnt_nxt = acq_cnt_r + 7'h01;
            end
          end else if (ext_fall) begin
            if (acq_cnt_r == {4'h0, `SAC_ACQ_EDGES} - 7'h01) begin
              state_nxt = ST_CONV;
            end else begin
              acq_cnt_nxt = acq_cnt_r + 7'h01;
            end
          end
          if (state_nxt == ST_CONV) begin
            step_nxt  = 4'h0;
            sar_nxt   = 10'h000;
            trial_nxt = 10'h200;
          end
        end
        ST_CONV: begin
          if (conv_tick) begin
            step_nxt = step_r + 4'h1;
            // Steps 1..10 resolve one bit each, MSB first
            if (step_nxt >= `SAC_SAR_FIRST && step_nxt <= `SAC_SAR_LAST) begin
              if (comparator_i) begin
                sar_nxt = sar_r | trial_r;
              end
              trial_nxt = trial_r >> 1;
            end
            if (step_nxt == `SAC_CONV_CYCLES) begin
              state_nxt  = ST_IDLE;
              result_nxt = fmt_res;
              done_n_nxt = 1'b0;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctrl_r    <= `SAC_CB_RESET;
      int_clk_r <= 1'b0;
      state_r   <= ST_IDLE;
      acq_cnt_r <= 7'h00;
      step_r    <= 4'h0;
      sar_r     <= 10'h000;
      trial_r   <= 10'h000;
      result_r  <= 10'h000;
      done_n_r  <= 1'b1;
    end else begin
      ctrl_r    <= ctrl_nxt;
      int_clk_r <= int_clk_nxt;
      state_r   <= state_nxt;
      acq_cnt_r <= acq_cnt_nxt;
      step_r    <= step_nxt;
      sar_r     <= sar_nxt;
      trial_r   <= trial_nxt;
      result_r  <= result_nxt;
      done_n_r  <= done_n_nxt;
    end
  end

  // Read data is registered; byte select is sampled each cycle
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      dout_r <= 8'h00;
    end else if (ubs_s) begin
      dout_r <= {{6{~uni_mode & result_r[`SAC_RES_MSB]}},
                 result_r[9:8]};
    end else begin
      dout_r <= result_r[7:0];
    end
  end

  assign parallel_data_pins_o  = dout_r;
  assign parallel_data_oe_n_o  = cs_n_s | rd_n_s;
  assign done_n_o              = done_n_r;
  assign done_oe_n_o           = cs_n_s;

  // Sample stage tracks only between a write and the hold point
  assign hold_capacitor_hold_o    = (state_r != ST_ACQ_EXT) &&
                                    (state_r != ST_ACQ_INT);
  assign hold_capacitor_convert_o = (state_r == ST_CONV);

  // Input pairing: pair partner differs in the address LSB
  assign pos_channel_o   = ctrl_r[`SAC_CB_CH_HI:`SAC_CB_CH_LO];
  assign neg_channel_o   = ctrl_r[`SAC_CB_CH_HI:`SAC_CB_CH_LO] ^
                           3'h1;
  assign neg_to_common_o = ctrl_r[`SAC_CB_PAIR];
  assign polarity_select_o = uni_mode;
  assign dac_code_o      = sar_r | trial_r;

  // Power-down takes effect only once no acquisition or conversion runs
  assign full_power_down_o = is_idle(state_r) &&
                             (pwr_code == `SAC_PWR_FULL_PD);
  assign standby_o         = is_idle(state_r) &&
                             (pwr_code == `SAC_PWR_STANDBY);
  assign internal_clock_o  = int_clk_r;

endmodule

// ==== tb/sac_properties.sv ====
// Port-level properties of the conversion sequencer
`timescale 1ns/100ps
module sac_checker (
  input wire       core_clk_i,
  input wire       reset_n_i,
  input wire       cs_n_i,
  input wire       wr_n_i,
  input wire       rd_n_i,
  input wire       upper_byte_select_i,
  input wire [7:0] parallel_data_pins_o,
  input wire       parallel_data_oe_n_o,
  input wire       done_n_o,
  input wire       done_oe_n_o,
  input wire       hold_capacitor_hold_o,
  input wire       hold_capacitor_convert_o,
  input wire [2:0] pos_channel_o,
  input wire [2:0] neg_channel_o,
  input wire       polarity_select_o,
  input wire       full_power_down_o,
  input wire       standby_o,
  input wire       internal_clock_o
);
  reg [9:0] conv_cnt_r;
  always @(posedge core_clk_i) begin
    if (!reset_n_i || !hold_capacitor_convert_o)
      conv_cnt_r <= 10'h0;
    else
      conv_cnt_r <= conv_cnt_r + 10'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_cs_released: assert property (cs_n_i [*3] |-> done_oe_n_o
    && parallel_data_oe_n_o) else $error("pins driven while deselected");
  a_write_tracks: assert property ($rose(wr_n_i) && !cs_n_i |-> ##[3:5]
    (!hold_capacitor_hold_o || hold_capacitor_convert_o))
    else $error("write did not start tracking");
  a_write_done: assert property ($rose(wr_n_i) && !cs_n_i |->
    ##[3:5] done_n_o) else $error("write left done low");
  a_read_done: assert property ($fell(rd_n_i) && !cs_n_i |->
    ##[3:5] done_n_o) else $error("read left done low");
  a_done_idle: assert property ($fell(done_n_o) |->
    hold_capacitor_hold_o && !hold_capacitor_convert_o)
    else $error("done while still converting");
  a_pair_map: assert property (neg_channel_o == (pos_channel_o ^ 3'h1))
    else $error("negative channel not the pair partner");
  a_conv_len: assert property ($fell(done_n_o) && internal_clock_o |->
    conv_cnt_r == 10'h15f)
    else $error("internal conversion length wrong");
  a_power_idle: assert property (full_power_down_o || standby_o |->
    hold_capacitor_hold_o && !hold_capacitor_convert_o)
    else $error("power down while busy");
  a_upper_fill: assert property ((!parallel_data_oe_n_o
    && upper_byte_select_i) [*4] |-> parallel_data_pins_o[7:2] ==
    {6{!polarity_select_o & parallel_data_pins_o[1]}})
    else $error("upper byte fill wrong");
endmodule
bind sac_sequencer sac_checker u_chk (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
  .upper_byte_select_i(upper_byte_select_i),
  .parallel_data_pins_o(parallel_data_pins_o),
  .parallel_data_oe_n_o(parallel_data_oe_n_o), .done_n_o(done_n_o),
  .done_oe_n_o(done_oe_n_o), .hold_capacitor_hold_o(hold_capacitor_hold_o),
  .hold_capacitor_convert_o(hold_capacitor_convert_o),
  .pos_channel_o(pos_channel_o), .neg_channel_o(neg_channel_o),
  .polarity_select_o(polarity_select_o), .standby_o(standby_o),
  .full_power_down_o(full_power_down_o), .internal_clock_o(internal_clock_o));

// ==== tb/sac_host_model.sv ====
// Host processor model on the byte-wide control and result port
`timescale 1ns/100ps
module sac_host_model (
  input  wire       clk_i,
  input  wire [7:0] dev_data_i,
  input  wire       dev_oe_n_i,
  output wire [7:0] bus_o,
  output reg        cs_n_o,
  output reg        wr_n_o,
  output reg        rd_n_o,
  output reg        ubs_o
);
  reg [7:0] drv_r = 8'h0;
  reg       drv_en_r = 1'b0;
  // A released bus shows the inverse of the last byte so stale data fails
  assign bus_o = !dev_oe_n_i ? dev_data_i : (drv_en_r ? drv_r : ~drv_r);
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    ubs_o = 1'b0;
  end
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // Chip select and fetch strobe levels, then one clock passes
  task set_pins(input c, input r);
    begin
      cs_n_o = c;
      rd_n_o = r;
      cyc(1);
    end
  endtask
  // Data held four cycles each side of the store edge for the input syncs
  task write_byte(input [7:0] b);
    begin
      drv_r = b;
      drv_en_r = 1'b1;
      wr_n_o = 1'b0;
      cyc(4);
      wr_n_o = 1'b1;
      cyc(4);
      drv_en_r = 1'b0;
    end
  endtask
  task read_byte(input u, output [7:0] v);
    begin
      ubs_o = u;
      rd_n_o = 1'b0;
      cyc(5);
      v = bus_o;
      rd_n_o = 1'b1;
      cyc(3);
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tb_top;
  reg        core_clk = 1'b0;
  reg        reset_n = 1'b0;
  reg        conv_clk = 1'b0;
  reg  [9:0] target = 10'h0;
  reg  [7:0] rv;
  integer    err_total = 0;
  integer    tests_run = 0;
  integer    wait_cnt;
  integer    k;
  wire [7:0] bus, dout;
  wire [9:0] dac;
  wire [2:0] pos, neg;
  wire       cs_n, wr_n, rd_n, ubs, doe_n, done_n, done_oe_n, hold, conv;
  wire       ncom, pol, fpd, stb, iclk;
  always #5 core_clk = ~core_clk;
  // External conversion clock of 220 ns, moving 1 ns after a core edge
  initial #6 forever #110 conv_clk = ~conv_clk;
  sac_host_model host (.clk_i(core_clk), .dev_data_i(dout),
    .dev_oe_n_i(doe_n), .bus_o(bus), .cs_n_o(cs_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .ubs_o(ubs));
  sac_sequencer DUT (.core_clk_i(core_clk), .reset_n_i(reset_n),
    .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .upper_byte_select_i(ubs),
    .conv_clk_i(conv_clk), .parallel_data_pins_i(bus),
    .comparator_i(dac <= target), .parallel_data_pins_o(dout),
    .parallel_data_oe_n_o(doe_n), .done_n_o(done_n), .done_oe_n_o(done_oe_n),
    .hold_capacitor_hold_o(hold), .hold_capacitor_convert_o(conv),
    .pos_channel_o(pos), .neg_channel_o(neg), .neg_to_common_o(ncom),
    .polarity_select_o(pol), .dac_code_o(dac), .full_power_down_o(fpd),
    .standby_o(stb), .internal_clock_o(iclk));
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wait_for(input on_conv);
    begin
      wait_cnt = 0;
      while ((on_conv ? conv !== 1'b1 : done_n !== 1'b0) && wait_cnt < 1000) begin
        host.cyc(1);
        wait_cnt = wait_cnt + 1;
      end
      chk("wait_limit", wait_cnt < 1000, 1);
    end
  endtask
  task rd_chk(input u, input [7:0] exp);
    begin
      host.read_byte(u, rv);
      chk("result", rv, exp);
      chk("done_rd", done_n, 1);
    end
  endtask
  task s_external;
    begin
      target = 10'h135;
      host.write_byte(8'h62);
      host.cyc(40);
      chk("ext_acq", {hold, conv, ncom, iclk, neg}, 7'h03);
      host.write_byte(8'hc2);
      chk("ext_conv", conv, 1);
      wait_for(0);
      chk("ext_len", wait_cnt >= 255 && wait_cnt <= 290, 1);
      rd_chk(0, 8'h35);
      rd_chk(1, 8'hff);
    end
  endtask
  task s_abort;
    begin
      host.write_byte(8'hd9);
      wait_for(1);
      chk("acq4", wait_cnt >= 58 && wait_cnt <= 90, 1);
      host.cyc(50);
      host.write_byte(8'hd9);
      chk("abort", {conv, hold, done_n}, 3'b001);
      wait_for(0);
      rd_chk(0, 8'h35);
    end
  endtask
  task s_internal;
    begin
      target = 10'h2b5;
      host.write_byte(8'h9d);
      chk("cfg", {ncom, pol, iclk, pos}, 6'h3d);
      chk("track", {hold, conv}, 2'b00);
      host.cyc(84);
      chk("acq_int", conv, 0);
      host.cyc(20);
      chk("conv_int", conv, 1);
      wait_for(0);
      chk("done", done_n, 0);
      rd_chk(0, 8'hb5);
      rd_chk(1, 8'h02);
    end
  endtask
  task s_power;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        host.write_byte(k ? 8'h5d : 8'h1d);
        wait_for(0);
        host.cyc(2);
        chk("power", {fpd, stb, iclk}, k ? 3'b011 : 3'b101);
        rd_chk(0, 8'hb5);
      end
    end
  endtask
  task s_deselect;
    begin
      host.set_pins(1'b1, 1'b0);
      host.cyc(4);
      chk("released", {doe_n, done_oe_n}, 2'b11);
      host.set_pins(1'b1, 1'b1);
      host.write_byte(8'h62);
      chk("ignored", {hold, conv}, 2'b10);
    end
  endtask
  task end_sim;
    begin
      if (err_total == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #200000;
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    host.cyc(2);
    reset_n = 1'b1;
    host.cyc(3);
    chk("reset", {iclk, done_n, hold, doe_n}, 4'h7);
    host.set_pins(1'b0, 1'b1);
    host.cyc(2);
    s_external;
    s_abort;
    s_internal;
    s_power;
    s_deselect;
    end_sim;
  end
endmodule
